// *** hdl/ulpsc_pkg.sv ***
// package for the ulpi transceiver start-up and bus control block
// assumes a 200 MHz core clock and a 60 MHz link clock made inside the device
package ulpsc_pkg;
    localparam int CORE_HZ = 200_000_000;
    localparam int PLL_LOCK_NS = 1000; // pll settle time after power
    localparam int PLL_LOCK_CYC = (PLL_LOCK_NS * (CORE_HZ / 1_000_000) + 999) / 1000;
    localparam int RST_DONE_CYC = 16; // internal reset length, link clocks
    localparam logic [2:0] PIN_RST_DIR_CYC = 3'h4; // dir falls after this many link clocks
    localparam logic [1:0] CMD_IDLE = 2'h0;
    localparam logic [1:0] CMD_TX = 2'h1;
    localparam logic [1:0] CMD_REGW = 2'h2;
    localparam logic [1:0] CMD_REGR = 2'h3;
    localparam logic [5:0] EXT_ADDR = 6'h2F;
    localparam int RXC_VBUS_POS = 2; // a-device vbus valid bit of the rxcmd
    typedef enum logic [3:0] {
        ULPSC_ST_RST = 4'b0001,
        ULPSC_ST_RXCMD = 4'b0010,
        ULPSC_ST_IDLE = 4'b0100,
        ULPSC_ST_CMD = 4'b1000
    } ulpsc_state_t;
endpackage

// *** hdl/ulpsc_sync3.sv ***
// three-flop synchroniser plus an output flop; change counted when stages two and three agree
// assumes the input is a slow level from another domain or a pin
`timescale 1ns/10ps
module ulpsc_sync3
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_d,
    output logic o_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            o_q <= 1'b0;
        end
        else
        begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                o_q <= s3_q;
            end
        end
    end
endmodule // ulpsc_sync3

// *** hdl/ulpsc_sync_if.sv ***
// interface carrying core-domain controls into the link-clock domain
// assumes both sides share one reset
`timescale 1ns/10ps
interface ulpsc_sync_if;
    logic pll_ok;
    logic soft_rst_req;
    logic soft_rst_ack;
    logic prot_dis;
    logic fault_mon;
    logic fault_lvl;
    modport core (output pll_ok, output soft_rst_req, input soft_rst_ack,
                  output prot_dis, output fault_mon, output fault_lvl);
    modport link (input pll_ok, input soft_rst_req, output soft_rst_ack,
                  input prot_dis, input fault_mon, input fault_lvl);
endinterface

// *** hdl/ulpsc_top.sv ***
// ulpi transceiver bus-side control: dir/nxt/data sequencing, protection, vbus
// assumes i_link_clk is the 60 MHz clock the device's pll makes
`timescale 1ns/10ps
module ulpsc_top
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_reset_pin_n,
    input wire logic i_chip_select_n,
    input wire logic i_stp,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_dir,
    output logic o_dir_oe,
    output logic o_nxt,
    output logic o_nxt_oe,
    output logic o_data_pulldown,
    output logic o_stp_pullup,
    output logic o_clk_out_en,
    output logic o_pll_power,
    input wire logic i_soft_reset_set,
    output logic o_soft_reset_bit,
    input wire logic i_interface_protect_disable,
    input wire logic i_internal_vbus_drive_bit,
    input wire logic i_external_vbus_drive_bit,
    output logic o_charge_pump_en,
    output logic o_power_switch_out_n,
    output logic o_power_switch_oe,
    input wire logic i_ext_vbus_indicator_enable,
    input wire logic i_indicator_passthrough_bit,
    input wire logic i_fault,
    input wire logic i_serial_mode,
    input wire logic [7:0] i_line_status,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_byte
);
    import ulpsc_pkg::*;
    ulpsc_sync_if sif ();
    logic cs_q;
    logic rstpin_q;
    logic fault_q;
    logic soft_req_q;
    logic ack_core;
    logic pll_on_q;
    logic pll_seen_q;
    logic [15:0] lock_cnt_q;
    // pins and the link-domain reset ack from outside the core domain
    ulpsc_sync3 u_cs (.i_clk(i_core_clk), .i_rst(i_rst), .i_d(~i_chip_select_n), .o_q(cs_q));
    ulpsc_sync3 u_rp (.i_clk(i_core_clk), .i_rst(i_rst), .i_d(~i_reset_pin_n), .o_q(rstpin_q));
    ulpsc_sync3 u_ft (.i_clk(i_core_clk), .i_rst(i_rst), .i_d(i_fault), .o_q(fault_q));
    ulpsc_sync3 u_ak (.i_clk(i_core_clk), .i_rst(i_rst), .i_d(sif.soft_rst_ack), .o_q(ack_core));
    // pll power turned on whenever chip select is seen while it is off; stays on after
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pll_on_q <= 1'b0;
            pll_seen_q <= 1'b0;
            lock_cnt_q <= 16'h0000;
        end
        else if (rstpin_q)
        begin
            // lock count survives the pin reset so dir can fall a few clocks after it
            pll_seen_q <= 1'b0;
        end
        else
        begin
            if (!pll_seen_q || !pll_on_q)
            begin
                pll_seen_q <= 1'b1;
                if (cs_q)
                begin
                    pll_on_q <= 1'b1;
                end
            end
            if (pll_on_q && lock_cnt_q != 16'(PLL_LOCK_CYC))
            begin
                lock_cnt_q <= lock_cnt_q + 16'h0001;
            end
        end
    end
    assign o_pll_power = pll_on_q;
    // software reset bit: set by software, cleared by hardware when done
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            soft_req_q <= 1'b0;
        end
        else if (i_soft_reset_set)
        begin
            soft_req_q <= 1'b1; // set beats the clear
        end
        else if (soft_req_q && ack_core)
        begin
            soft_req_q <= 1'b0;
        end
    end
    assign o_soft_reset_bit = soft_req_q;
    assign sif.pll_ok = (lock_cnt_q == 16'(PLL_LOCK_CYC));
    assign sif.soft_rst_req = soft_req_q;
    assign sif.prot_dis = i_interface_protect_disable;
    assign sif.fault_mon = i_ext_vbus_indicator_enable && i_indicator_passthrough_bit;
    assign sif.fault_lvl = fault_q;
    // vbus source selection, open-drain switch pulled low when enabled
    assign o_charge_pump_en = i_internal_vbus_drive_bit && !i_external_vbus_drive_bit;
    assign o_power_switch_out_n = 1'b0;
    assign o_power_switch_oe = i_external_vbus_drive_bit;
    // link-clock domain
    logic pll_ok_l;
    logic req_l;
    logic mon_l;
    logic flt_l;
    logic pdis_l;
    logic cs_l;
    logic stp_l;
    logic rp_l;
    logic turn_q;
    logic rxc_hold_q;
    ulpsc_sync3 u_l0 (.i_clk(i_link_clk), .i_rst(i_rst), .i_d(sif.pll_ok), .o_q(pll_ok_l));
    ulpsc_sync3 u_l1 (.i_clk(i_link_clk), .i_rst(i_rst), .i_d(sif.soft_rst_req), .o_q(req_l));
    ulpsc_sync3 u_l2 (.i_clk(i_link_clk), .i_rst(i_rst), .i_d(sif.fault_mon), .o_q(mon_l));
    ulpsc_sync3 u_l3 (.i_clk(i_link_clk), .i_rst(i_rst), .i_d(sif.fault_lvl), .o_q(flt_l));
    ulpsc_sync3 u_l4 (.i_clk(i_link_clk), .i_rst(i_rst), .i_d(sif.prot_dis), .o_q(pdis_l));
    ulpsc_sync3 u_l5 (.i_clk(i_link_clk), .i_rst(i_rst), .i_d(~i_chip_select_n), .o_q(cs_l));
    ulpsc_sync3 u_l6 (.i_clk(i_link_clk), .i_rst(i_rst), .i_d(~i_reset_pin_n), .o_q(rp_l));
    // stp is launched by the link on this same clock, so it needs no synchroniser
    assign stp_l = i_stp;
    ulpsc_state_t st_q;
    logic [4:0] rcnt_q;
    logic [2:0] dcnt_q;
    logic ack_q;
    logic rxc_pend_q;
    logic rxc_q;
    logic [7:0] status_q;
    logic [7:0] data_q;
    logic nxt_q;
    logic cmd_v_q;
    logic [7:0] cmd_q;
    logic [7:0] cur_status;
    logic stp_exit_q;
    assign cur_status = {i_line_status[7:3], mon_l ? flt_l : i_line_status[RXC_VBUS_POS],
                         i_line_status[1:0]};
    assign sif.soft_rst_ack = ack_q;
    // reset and bus sequencer
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= ULPSC_ST_RST;
            rcnt_q <= 5'h00;
            dcnt_q <= 3'h0;
            ack_q <= 1'b0;
            rxc_pend_q <= 1'b0;
            status_q <= 8'h00;
            nxt_q <= 1'b0;
            cmd_v_q <= 1'b0;
            cmd_q <= 8'h00;
        end
        else
        begin
            cmd_v_q <= 1'b0;
            if (!req_l)
            begin
                ack_q <= 1'b0;
            end
            case (st_q)
                ULPSC_ST_RST:
                begin
                    nxt_q <= 1'b0;
                    if (!pll_ok_l)
                    begin
                        dcnt_q <= 3'h0;
                    end
                    else if (dcnt_q != PIN_RST_DIR_CYC)
                    begin
                        dcnt_q <= dcnt_q + 3'h1;
                    end
                    else
                    begin
                        st_q <= ULPSC_ST_RXCMD;
                        rxc_pend_q <= 1'b1;
                    end
                end
                ULPSC_ST_RXCMD:
                begin
                    nxt_q <= 1'b0;
                    rxc_pend_q <= 1'b0;
                    status_q <= cur_status;
                    st_q <= ULPSC_ST_IDLE;
                end
                ULPSC_ST_IDLE:
                begin
                    nxt_q <= 1'b0;
                    if (!cs_l)
                    begin
                        st_q <= ULPSC_ST_IDLE;
                    end
                    else if (req_l && !ack_q)
                    begin
                        st_q <= ULPSC_ST_RST;
                        rcnt_q <= 5'h00;
                        dcnt_q <= 3'h0;
                    end
                    else if (cur_status != status_q)
                    begin
                        st_q <= ULPSC_ST_RXCMD;
                    end
                    else if (i_data != 8'h00 && !rxc_q && !turn_q && !stp_l)
                    begin
                        nxt_q <= 1'b1;
                        cmd_v_q <= 1'b1;
                        cmd_q <= i_data;
                        st_q <= ULPSC_ST_CMD;
                    end
                end
                ULPSC_ST_CMD:
                begin
                    nxt_q <= 1'b0;
                    if (stp_l || !cs_l)
                    begin
                        st_q <= ULPSC_ST_IDLE;
                    end
                end
                default:
                begin
                    st_q <= ULPSC_ST_RST;
                end
            endcase
            if (st_q == ULPSC_ST_RST && req_l && !ack_q)
            begin
                // internal reset time before release, then acknowledge
                if (rcnt_q != 5'(RST_DONE_CYC))
                begin
                    rcnt_q <= rcnt_q + 5'h01;
                    dcnt_q <= 3'h0;
                end
                else
                begin
                    ack_q <= 1'b1;
                end
            end
            if (rp_l)
            begin
                // pin reset: controller idles, the byte shown meanwhile is the rxcmd
                st_q <= ULPSC_ST_IDLE;
                status_q <= cur_status;
                nxt_q <= 1'b0;
                cmd_v_q <= 1'b0;
                rcnt_q <= 5'h00;
                dcnt_q <= 3'h0;
            end
        end
    end
    // serial/suspend mode is left by stp even while deselected
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stp_exit_q <= 1'b0;
        end
        else
        begin
            stp_exit_q <= i_serial_mode && stp_l;
        end
    end
    // rxcmd data register; dir high during reset and rxcmd
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            data_q <= 8'h00;
            rxc_q <= 1'b1;
            rxc_hold_q <= 1'b0;
            turn_q <= 1'b1;
        end
        else
        begin
            data_q <= cur_status;
            // one extra dir cycle so the link's turnaround does not eat the byte
            rxc_hold_q <= (st_q == ULPSC_ST_RXCMD);
            rxc_q <= rp_l || rxc_hold_q || (st_q == ULPSC_ST_RST)
                     || (st_q == ULPSC_ST_RXCMD);
            turn_q <= rxc_q; // bus undriven for one cycle after dir falls
        end
    end
    assign o_dir = rxc_q;
    assign o_dir_oe = cs_l;
    assign o_nxt = nxt_q && !rxc_q;
    assign o_nxt_oe = cs_l;
    assign o_data = data_q;
    assign o_data_oe = cs_l && rxc_q;
    assign o_clk_out_en = pll_ok_l && st_q != ULPSC_ST_RST;
    assign o_stp_pullup = 1'b1;
    assign o_data_pulldown = cs_l && !pdis_l && stp_l && st_q == ULPSC_ST_IDLE
                             && !stp_exit_q;
    assign o_cmd_valid = cmd_v_q;
    assign o_cmd_byte = cmd_q;
    // checks
    property p_nxt_low_dir;
        @(posedge i_link_clk) disable iff (i_rst) o_dir |-> !o_nxt;
    endproperty
    a_nxt_low_dir: assert property (p_nxt_low_dir) else $error("nxt high with dir");
    property p_pd_dis;
        @(posedge i_link_clk) disable iff (i_rst) pdis_l |-> !o_data_pulldown;
    endproperty
    a_pd_dis: assert property (p_pd_dis) else $error("pulldown despite disable");
    property p_cp;
        @(posedge i_core_clk) disable iff (i_rst)
            i_external_vbus_drive_bit |-> (o_power_switch_oe && !o_charge_pump_en);
    endproperty
    a_cp: assert property (p_cp) else $error("vbus source wrong");
    property p_cmd;
        @(posedge i_link_clk) disable iff (i_rst)
            (st_q == ULPSC_ST_IDLE && cs_l && !(req_l && !ack_q) && cur_status == status_q
             && i_data != 8'h00 && !rxc_q && !turn_q && !stp_l && !rp_l)
            |=> (nxt_q && cmd_q == $past(i_data));
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not accepted");
    property p_rxc_after_rst;
        @(posedge i_link_clk) disable iff (i_rst)
            (st_q == ULPSC_ST_RST && pll_ok_l && dcnt_q == PIN_RST_DIR_CYC
             && !(req_l && !ack_q) && !rp_l)
            |=> (st_q == ULPSC_ST_RXCMD && rxc_pend_q);
    endproperty
    a_rxc_after_rst: assert property (p_rxc_after_rst) else $error("no rxcmd");
    property p_dir_hold;
        @(posedge i_link_clk) disable iff (i_rst) !pll_ok_l |=> o_dir;
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("dir low before ready");
    property p_oe;
        @(posedge i_link_clk) disable iff (i_rst) !cs_l |-> !o_dir_oe && !o_data_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("driving while deselected");
    property p_soft_clr;
        @(posedge i_core_clk) disable iff (i_rst)
            (soft_req_q && ack_core && !i_soft_reset_set) |=> !soft_req_q;
    endproperty
    a_soft_clr: assert property (p_soft_clr) else $error("reset bit not cleared");
endmodule // ulpsc_top

// *** sim/ulpsc_link_model.sv ***
// link controller model for the far side of the ulpi bus
// assumes the bench resolves the shared data and stp wires
`timescale 1ns/10ps
module ulpsc_link_model
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_dir,
    input wire logic i_nxt,
    input wire logic i_reset_pin_n,
    input wire logic [7:0] i_bus,
    input wire logic i_go,
    input wire logic [7:0] i_cmd,
    input wire logic i_release,
    input wire logic i_reset_issued,
    output logic o_busy,
    output logic o_ready,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_stp,
    output logic [7:0] o_rx_byte,
    output logic o_rx_stb
);
    logic dir_q;
    logic rx_ok_q;
    logic [1:0] low_cnt_q;
    // drive once dir has been low a full cycle, or while the reset pin is low; release mimics an unpowered link
    assign o_data_oe = !i_release && (!i_reset_pin_n || (!i_dir && !dir_q));
    assign o_ready = (low_cnt_q == 2'h3);
    // dir watch and status capture; the turnaround cycle after dir rises is skipped
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dir_q <= 1'b1;
            low_cnt_q <= 2'h0;
            rx_ok_q <= 1'b0;
            o_rx_stb <= 1'b0;
            o_rx_byte <= 8'h00;
        end
        else
        begin
            dir_q <= i_dir;
            low_cnt_q <= i_dir ? 2'h0 : low_cnt_q + {1'b0, !o_ready};
            rx_ok_q <= rx_ok_q | i_reset_issued;
            o_rx_stb <= !i_dir && dir_q && rx_ok_q;
            if (i_dir && dir_q)
                o_rx_byte <= i_bus;
        end
    end
    // one command byte held until nxt, then a stp pulse and back to 00h
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_busy <= 1'b0;
            o_data <= 8'h00;
            o_stp <= 1'b0;
        end
        else
        begin
            o_stp <= 1'b0;
            if (!i_reset_pin_n)
            begin
                o_busy <= 1'b0;
                o_data <= 8'h00;
            end
            else if (o_busy && i_nxt && !i_dir)
            begin
                o_busy <= 1'b0;
                o_data <= 8'h00;
                o_stp <= 1'b1;
            end
            else if (i_go && !o_busy && o_ready)
            begin
                o_busy <= 1'b1;
                o_data <= i_cmd;
            end
        end
    end
endmodule // ulpsc_link_model

// *** sim/ulpsc_top_bench.sv ***
// self-checking bench for the ulpi bus-side control block
// assumes a free-running device-made link clock
`timescale 1ns/10ps
module ulpsc_top_bench;
    import ulpsc_pkg::*;
    logic i_core_clk = 1'b0, i_link_clk = 1'b0, i_rst = 1'b1, i_reset_pin_n = 1'b1;
    logic i_chip_select_n = 1'b0, i_soft_reset_set = 1'b0, i_interface_protect_disable = 1'b0;
    logic i_internal_vbus_drive_bit = 1'b0, i_external_vbus_drive_bit = 1'b0, i_fault = 1'b0;
    logic i_ext_vbus_indicator_enable = 1'b0, i_indicator_passthrough_bit = 1'b0;
    logic i_serial_mode = 1'b0, i_stp;
    logic [7:0] i_line_status = 8'h00, i_data, o_data, o_cmd_byte, bus_last = 8'h00, line;
    logic o_data_oe, o_dir, o_dir_oe, o_nxt, o_nxt_oe, o_data_pulldown, o_stp_pullup;
    logic o_clk_out_en, o_pll_power, o_soft_reset_bit, o_charge_pump_en, o_cmd_valid;
    logic o_power_switch_out_n, o_power_switch_oe;
    logic lk_go = 1'b0, lk_release = 1'b0, lk_rst_iss = 1'b0;
    logic lk_busy, lk_ready, lk_data_oe, lk_stp, lk_rx_stb;
    logic [7:0] lk_cmd = 8'h00, lk_data, lk_rx_byte;
    logic [7:0] cmd_q[$];
    logic [7:0] rx_q[$];
    int n_errors = 0;
    int checks_done = 0;
    int n;
    always #2.5 i_core_clk = ~i_core_clk;
    // link clock offset so its edges drift against the core clock
    initial
    begin
        #1.7;
        forever #3 i_link_clk = ~i_link_clk;
    end
    // device wins, then link, then pull-down; a floating bus keeps changing
    assign i_data = (o_data_oe === 1'b1) ? o_data : lk_data_oe ? lk_data :
                    (o_data_pulldown === 1'b1) ? 8'h00 : ~bus_last;
    assign i_stp = lk_release ? o_stp_pullup : lk_stp;
    always @(posedge i_link_clk) bus_last <= i_data;
    ulpsc_top u_dut (.*);
    ulpsc_link_model u_link (.i_clk(i_link_clk), .i_rst(i_rst), .i_dir(o_dir), .i_nxt(o_nxt),
        .i_reset_pin_n(i_reset_pin_n), .i_bus(i_data), .i_go(lk_go), .i_cmd(lk_cmd),
        .i_release(lk_release), .i_reset_issued(lk_rst_iss), .o_busy(lk_busy),
        .o_ready(lk_ready), .o_data(lk_data), .o_data_oe(lk_data_oe), .o_stp(lk_stp),
        .o_rx_byte(lk_rx_byte), .o_rx_stb(lk_rx_stb));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // wait link edges, then land on a core falling edge to drive
    task automatic lk(input int k);
        repeat (k) @(posedge i_link_clk);
        @(negedge i_core_clk);
    endtask
    // count link edges until dir falls, bounded
    task automatic wait_dir(output int k);
        k = 0;
        while (o_dir !== 1'b0 && k < 3000)
        begin
            @(posedge i_link_clk);
            #0.5;
            k++;
        end
        @(negedge i_core_clk);
    endtask
    // the model holds the byte until nxt; the expected capture is noted first
    task automatic send(input logic [7:0] c);
        int k;
        cmd_q.push_back(c);
        lk_cmd = c;
        lk_go = 1'b1;
        for (k = 0; k < 400 && lk_busy !== 1'b1; k++) @(negedge i_core_clk);
        lk_go = 1'b0;
        for (k = 0; k < 400 && lk_busy !== 1'b0; k++) @(negedge i_core_clk);
    endtask
    // results are matched against the oldest note
    always @(negedge i_link_clk)
    begin
        if (o_cmd_valid === 1'b1)
            check(o_cmd_byte, (cmd_q.size() > 0) ? cmd_q.pop_front() : 8'hXX);
        if (lk_rx_stb === 1'b1 && rx_q.size() > 0)
            check(lk_rx_byte, rx_q.pop_front());
        if (o_dir === 1'b1 && o_nxt !== 1'b0)
            check(o_nxt, 1'b0);
    end
    initial
    begin
        #400000;
        n_errors++;
        test_done();
    end
    initial
    begin
        void'($urandom(51932));
        line = 8'($urandom()) & ~(8'h01 << RXC_VBUS_POS);
        i_line_status = line;
        repeat (20) @(posedge i_core_clk);
        @(negedge i_core_clk);
        check(o_dir, 1'b1);
        i_rst = 1'b0;
        cy2: repeat (8) @(negedge i_core_clk);
        check({o_dir, o_clk_out_en, o_pll_power, o_stp_pullup}, 4'hB);
        wait_dir(n);
        check(8'(n < 3000), 8'h01);
        check(o_clk_out_en, 1'b1);
        // register reset; the status byte must be the last one before dir falls
        lk_rst_iss = 1'b1;
        rx_q.push_back(line);
        i_soft_reset_set = 1'b1;
        @(negedge i_core_clk);
        i_soft_reset_set = 1'b0;
        lk(10);
        check({o_dir, o_soft_reset_bit}, 2'h3);
        wait_dir(n);
        lk(6);
        check({o_dir, o_soft_reset_bit}, 2'h0);
        check(8'(rx_q.size()), 8'h00);
        // each non-idle command class, back to back
        send({CMD_TX, 2'h0, 4'($urandom())});
        send({CMD_REGW, 6'($urandom())});
        send({CMD_REGR, 6'($urandom())});
        send({CMD_REGW, EXT_ADDR});
        send({CMD_REGR, EXT_ADDR});
        lk(6);
        check(8'(cmd_q.size()), 8'h00);
        // fault passthrough on, both edges of the fault input reported
        i_ext_vbus_indicator_enable = 1'b1;
        i_indicator_passthrough_bit = 1'b1;
        lk(10);
        rx_q.push_back(line | (8'h01 << RXC_VBUS_POS));
        i_fault = 1'b1;
        lk(60);
        rx_q.push_back(line);
        i_fault = 1'b0;
        lk(60);
        check(8'(rx_q.size()), 8'h00);
        i_indicator_passthrough_bit = 1'b0;
        lk(10);
        i_fault = 1'b1;
        n = 0;
        repeat (60) @(posedge i_link_clk) n += int'(o_dir === 1'b1);
        check(8'(n), 8'h00);
        // undriven link: stp floats high through its pull-up
        lk_release = 1'b1;
        lk(8);
        check(o_data_pulldown, 1'b1);
        i_interface_protect_disable = 1'b1;
        lk(8);
        check(o_data_pulldown, 1'b0);
        i_interface_protect_disable = 1'b0;
        i_chip_select_n = 1'b1;
        lk(8);
        check({o_data_pulldown, o_data_oe, o_dir_oe, o_nxt_oe}, 4'h0);
        i_chip_select_n = 1'b0;
        lk_release = 1'b0;
        for (int v = 0; v < 4; v++)
        begin
            {i_internal_vbus_drive_bit, i_external_vbus_drive_bit} = 2'(v);
            repeat (4) @(negedge i_core_clk);
            check({o_charge_pump_en, o_power_switch_oe, o_power_switch_out_n},
                  (v == 2) ? 3'h4 : v[0] ? 3'h2 : 3'h0);
        end
        i_reset_pin_n = 1'b0;
        lk(6);
        check(o_dir, 1'b1);
        i_reset_pin_n = 1'b1;
        wait_dir(n);
        check(8'(n >= 4 && n <= 5), 8'h01);
        // second power-up with the chip deselected
        i_chip_select_n = 1'b1;
        i_rst = 1'b1;
        repeat (4) @(negedge i_core_clk);
        i_rst = 1'b0;
        repeat (20) @(negedge i_core_clk);
        check(o_pll_power, 1'b0);
        test_done();
    end
endmodule // ulpsc_top_bench
